// [hw/srmc_regs.svh]
// Register offsets, field positions and fixed figures of the region crop block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef SRMC_REGS_SVH
`define SRMC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SRMC_OFS_CTRL 12'h000
`define SRMC_OFS_SENSOR 12'h004
`define SRMC_OFS_MAX 12'h008
`define SRMC_OFS_WIN_SIZE 12'h00c
`define SRMC_OFS_WIN_START 12'h010
`define SRMC_OFS_REG_SEL 12'h014
`define SRMC_OFS_REG_EN 12'h018
`define SRMC_OFS_REG_COLS 12'h01c
`define SRMC_OFS_REG_ROWS 12'h020
`define SRMC_OFS_REG_START 12'h024
`define SRMC_OFS_STATUS 12'h028
`define SRMC_OFS_OUT_SIZE 12'h02c
`define SRMC_OFS_USERSET 12'h030

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRMC_CTRL_MULTI 0
`define SRMC_STAT_OK 0
`define SRMC_STAT_ACTIVE 1
`define SRMC_USER_SAVE 0
`define SRMC_USER_LOAD 1

// ----------------------------------------
// Granularity and minimum sizes
// ----------------------------------------
`define SRMC_COL_STEP_MASK 16'h000f
`define SRMC_ROW_STEP_MASK 16'h0001
`define SRMC_MIN_COLS 16'h0040
`define SRMC_MIN_ROWS 16'h0004

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRMC_RST_CTRL 32'h0000_0000
`define SRMC_RST_SEL 5'h00

`endif

// [hw/srmc_pkg.sv]
// Types shared by the region crop block.
// Assumes 16-bit pixel coordinates.
package srmc_pkg;
	typedef logic [15:0] srmc_coord_t;

	// One region of the multi-region set
	typedef struct packed {
		logic en;
		srmc_coord_t col_start;
		srmc_coord_t row_start;
		srmc_coord_t rows;
	} srmc_region_t;
endpackage : srmc_pkg

// [hw/srmc_top.sv]
// Sensor window and multi-region crop with an APB register file.
// Assumes a raster pixel stream with frame-start and end-of-row marks,
// no back-pressure on either side, and one 20 MHz clock.
//
// What this block does
// - Offsets count from upper-left pixel zero
// - Single window passes only its rectangle
// - Window size resets to maximum values
// - Window width step 16, height step 2
// - Window at least 64 wide, 4 high
// - Sensor size is read-only
// - Maximum image size reported, fixed at sensor size
// - Thirty-two regions chosen by index select
// - Multi mode passes enabled regions, merged
// - Each region has its own enable
// - Common width, own height and offsets
// - Output width common, height sum enabled
// - Region offset plus size within sensor
// - Region columns step 16, rows step 2
// - Validity flag for multi-region settings
// - Read-only multi-region active status
// - Region settings saved and restored as set
`include "srmc_regs.svh"

module srmc_top #(
	parameter int PIX_W = 12,
	parameter int NUM_REGIONS = 32,
	parameter logic [15:0] SENSOR_COLS = 16'd11264,
	parameter logic [15:0] SENSOR_ROWS = 16'd9200
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic in_valid,
	input wire logic in_sof,
	input wire logic in_eol,
	input wire logic [PIX_W-1:0] in_data,
	output logic out_valid,
	output logic out_sof,
	output logic out_eol,
	output logic [PIX_W-1:0] out_data
);
	import srmc_pkg::*;

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic multi_req, next_multi_req;
	srmc_coord_t win_cols, next_win_cols, win_rows, next_win_rows;
	srmc_coord_t win_col0, next_win_col0, win_row0, next_win_row0;
	logic [4:0] sel, next_sel;
	srmc_coord_t common_cols, next_common_cols, saved_cols, next_saved_cols;
	srmc_region_t region [NUM_REGIONS];
	srmc_region_t next_region [NUM_REGIONS];
	srmc_region_t saved [NUM_REGIONS];
	srmc_region_t next_saved [NUM_REGIONS];
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	logic access, wr, known;
	logic [31:0] rd_val;
	srmc_coord_t wlo, whi;
	logic [4:0] sel_w;
	logic [15:0] col_mask, row_mask;

	// Derived status
	logic cfg_ok, multi_active;
	logic [16:0] out_rows_sum;
	srmc_coord_t out_cols, out_rows;

	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign wlo = pwdata[15:0];
	assign whi = pwdata[31:16];
	assign sel_w = sel;
	assign col_mask = `SRMC_COL_STEP_MASK;
	assign row_mask = `SRMC_ROW_STEP_MASK;
	assign multi_active = multi_req && cfg_ok;

	// ----------------------------------------
	// Validity and merged size
	// ----------------------------------------
	always_comb begin
		logic any_en;
		logic ok;
		logic [16:0] sum;
		any_en = 1'b0;
		ok = (common_cols != 16'h0000) && ((common_cols & col_mask) == 16'h0000);
		sum = 17'h00000;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (region[i].en) begin
				any_en = 1'b1;
				sum = sum + {1'b0, region[i].rows};
				if ({1'b0, region[i].col_start} + {1'b0, common_cols} > {1'b0, SENSOR_COLS})
					ok = 1'b0;
				if ({1'b0, region[i].row_start} + {1'b0, region[i].rows} > {1'b0, SENSOR_ROWS})
					ok = 1'b0;
				if (region[i].rows == 16'h0000)
					ok = 1'b0;
			end
		end
		cfg_ok = ok && any_en;
		out_rows_sum = sum;
	end

	assign out_cols = multi_active ? common_cols : win_cols;
	assign out_rows = multi_active ? out_rows_sum[15:0] : win_rows;

	// ----------------------------------------
	// APB register file
	// ----------------------------------------
	always_comb begin
		next_multi_req = multi_req;
		next_win_cols = win_cols;
		next_win_rows = win_rows;
		next_win_col0 = win_col0;
		next_win_row0 = win_row0;
		next_sel = sel;
		next_common_cols = common_cols;
		next_saved_cols = saved_cols;
		next_region = region;
		next_saved = saved;
		known = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`SRMC_OFS_CTRL: rd_val[`SRMC_CTRL_MULTI] = multi_req;
			`SRMC_OFS_SENSOR: rd_val = {SENSOR_ROWS, SENSOR_COLS};
			`SRMC_OFS_MAX: rd_val = {SENSOR_ROWS, SENSOR_COLS};
			`SRMC_OFS_WIN_SIZE: rd_val = {win_rows, win_cols};
			`SRMC_OFS_WIN_START: rd_val = {win_row0, win_col0};
			`SRMC_OFS_REG_SEL: rd_val[4:0] = sel;
			`SRMC_OFS_REG_EN: rd_val[0] = region[sel_w].en;
			`SRMC_OFS_REG_COLS: rd_val[15:0] = common_cols;
			`SRMC_OFS_REG_ROWS: rd_val[15:0] = region[sel_w].rows;
			`SRMC_OFS_REG_START: rd_val = {region[sel_w].row_start, region[sel_w].col_start};
			`SRMC_OFS_STATUS: begin
				rd_val[`SRMC_STAT_OK] = cfg_ok;
				rd_val[`SRMC_STAT_ACTIVE] = multi_active;
			end
			`SRMC_OFS_OUT_SIZE: rd_val = {out_rows, out_cols};
			`SRMC_OFS_USERSET: rd_val = 32'h0000_0000;
			default: known = 1'b0;
		endcase
		if (wr) begin
			case (paddr)
				`SRMC_OFS_CTRL: next_multi_req = pwdata[`SRMC_CTRL_MULTI];
				`SRMC_OFS_WIN_SIZE: begin
					// Illegal sizes are dropped whole; the old window stays in force
					if (((wlo & col_mask) == 16'h0000) && ((whi & row_mask) == 16'h0000)
						&& (wlo >= `SRMC_MIN_COLS) && (whi >= `SRMC_MIN_ROWS)
						&& (wlo <= SENSOR_COLS) && (whi <= SENSOR_ROWS)) begin
						next_win_cols = wlo;
						next_win_rows = whi;
					end
				end
				`SRMC_OFS_WIN_START: begin
					next_win_col0 = wlo;
					next_win_row0 = whi;
				end
				`SRMC_OFS_REG_SEL: next_sel = pwdata[4:0];
				`SRMC_OFS_REG_EN: next_region[sel_w].en = pwdata[0];
				`SRMC_OFS_REG_COLS: begin
					if ((wlo & col_mask) == 16'h0000)
						next_common_cols = wlo;
				end
				`SRMC_OFS_REG_ROWS: begin
					if ((wlo & row_mask) == 16'h0000)
						next_region[sel_w].rows = wlo;
				end
				`SRMC_OFS_REG_START: begin
					if (((wlo & col_mask) == 16'h0000) && ((whi & row_mask) == 16'h0000)) begin
						next_region[sel_w].col_start = wlo;
						next_region[sel_w].row_start = whi;
					end
				end
				`SRMC_OFS_USERSET: begin
					// Save wins if both bits are set in one write
					if (pwdata[`SRMC_USER_SAVE]) begin
						next_saved = region;
						next_saved_cols = common_cols;
					end else if (pwdata[`SRMC_USER_LOAD]) begin
						next_region = saved;
						next_common_cols = saved_cols;
					end
				end
				default: ;
			endcase
		end
		// No wait state: answer is prepared during the setup cycle
		next_pready = psel && !penable;
		next_prdata = (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
		next_pslverr = psel && !penable && !known;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			multi_req <= 1'b0;
			win_cols <= SENSOR_COLS;
			win_rows <= SENSOR_ROWS;
			win_col0 <= 16'h0000;
			win_row0 <= 16'h0000;
			sel <= `SRMC_RST_SEL;
			common_cols <= 16'h0000;
			saved_cols <= 16'h0000;
			for (int i = 0; i < NUM_REGIONS; i++) begin
				region[i] <= '0;
				saved[i] <= '0;
			end
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			multi_req <= next_multi_req;
			win_cols <= next_win_cols;
			win_rows <= next_win_rows;
			win_col0 <= next_win_col0;
			win_row0 <= next_win_row0;
			sel <= next_sel;
			common_cols <= next_common_cols;
			saved_cols <= next_saved_cols;
			region <= next_region;
			saved <= next_saved;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------
	// Pixel position and keep decision
	// ----------------------------------------
	srmc_coord_t col_cnt, next_col_cnt, row_cnt, next_row_cnt;
	srmc_coord_t cur_col, cur_row;
	logic frame_multi, next_frame_multi, first_done, next_first_done;
	logic keep, last_col;
	logic next_out_valid, next_out_sof, next_out_eol;
	logic [PIX_W-1:0] next_out_data;

	// Coordinates count from the upper-left pixel
	assign cur_col = in_sof ? 16'h0000 : col_cnt;
	assign cur_row = in_sof ? 16'h0000 : row_cnt;

	always_comb begin
		logic hit;
		logic [16:0] c, r;
		logic [16:0] c0, cw, r0, rh;
		hit = 1'b0;
		c = {1'b0, cur_col};
		r = {1'b0, cur_row};
		c0 = {1'b0, win_col0};
		cw = {1'b0, win_cols};
		r0 = {1'b0, win_row0};
		rh = {1'b0, win_rows};
		keep = 1'b0;
		last_col = 1'b0;
		// Mode is frozen per frame so a frame never mixes the two geometries
		if (in_sof ? multi_active : frame_multi) begin
			cw = {1'b0, common_cols};
			// Lowest region index wins where regions share a row; a row is sent once
			for (int i = 0; i < NUM_REGIONS; i++) begin
				r0 = {1'b0, region[i].row_start};
				rh = {1'b0, region[i].rows};
				c0 = {1'b0, region[i].col_start};
				if (!hit && region[i].en && r >= r0 && r < r0 + rh) begin
					hit = 1'b1;
					keep = (c >= c0) && (c < c0 + cw);
					last_col = (c == c0 + cw - 17'h00001);
				end
			end
		end else begin
			keep = (c >= c0) && (c < c0 + cw) && (r >= r0) && (r < r0 + rh);
			last_col = (c == c0 + cw - 17'h00001);
		end
	end

	always_comb begin
		next_col_cnt = col_cnt;
		next_row_cnt = row_cnt;
		next_frame_multi = frame_multi;
		next_first_done = first_done;
		next_out_valid = 1'b0;
		next_out_sof = 1'b0;
		next_out_eol = 1'b0;
		next_out_data = out_data;
		if (in_valid) begin
			if (in_sof) begin
				next_frame_multi = multi_active;
				next_first_done = 1'b0;
			end
			// Sensor raster order gives ascending output rows
			if (in_eol) begin
				next_col_cnt = 16'h0000;
				next_row_cnt = cur_row + 16'h0001;
			end else begin
				next_col_cnt = cur_col + 16'h0001;
				next_row_cnt = cur_row;
			end
			if (keep) begin
				next_out_valid = 1'b1;
				next_out_data = in_data;
				next_out_sof = in_sof ? 1'b1 : !first_done;
				next_out_eol = last_col || in_eol;
				next_first_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			col_cnt <= 16'h0000;
			row_cnt <= 16'h0000;
			frame_multi <= 1'b0;
			first_done <= 1'b0;
			out_valid <= 1'b0;
			out_sof <= 1'b0;
			out_eol <= 1'b0;
			out_data <= '0;
		end else begin
			col_cnt <= next_col_cnt;
			row_cnt <= next_row_cnt;
			frame_multi <= next_frame_multi;
			first_done <= next_first_done;
			out_valid <= next_out_valid;
			out_sof <= next_out_sof;
			out_eol <= next_out_eol;
			out_data <= next_out_data;
		end
	end
endmodule : srmc_top

// [bench/srmc_chk.sv]
// Checker for the crop block: APB timing and pixel stream relations.
// Assumes it is bound to srmc_top and sees only its ports.
module srmc_chk #(
	parameter int PIX_W = 12
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic in_valid,
	input wire logic in_sof,
	input wire logic in_eol,
	input wire logic [PIX_W-1:0] in_data,
	input wire logic out_valid,
	input wire logic out_sof,
	input wire logic out_eol,
	input wire logic [PIX_W-1:0] out_data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	ready_access_a: assert property (pready |-> psel && penable ##1 !pready)
		else $error("pready outside one access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_quiet_a: assert property (!pready || pwrite |-> prdata == 32'h0)
		else $error("prdata outside read access");
	pixel_cause_a: assert property (
		out_valid |-> $past(in_valid) && out_data == $past(in_data))
		else $error("kept pixel differs from input");
	data_hold_a: assert property (!out_valid |-> $stable(out_data))
		else $error("out_data moved without a pixel");
	flags_kept_a: assert property (out_sof || out_eol |-> out_valid)
		else $error("frame mark without pixel");
	no_input_a: assert property (!in_valid |=> !out_valid)
		else $error("output cycle without input");

	cover property (pslverr);
	cover property (out_valid && out_sof);
	cover property (out_valid && out_eol ##1 out_valid);
endmodule : srmc_chk

bind srmc_top srmc_chk #(.PIX_W(PIX_W)) i_srmc_chk (.clock, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_sof, .in_eol, .in_data,
	.out_valid, .out_sof, .out_eol, .out_data);

// [bench/srmc_grabber.sv]
// Frame grabber model: counts kept pixels and rows of each frame.
// Assumes no back-pressure; a frame restarts at every marked first pixel.
module srmc_grabber #(
	parameter int PIX_W = 12
) (
	input wire logic clock,
	input wire logic out_valid,
	input wire logic out_sof,
	input wire logic out_eol,
	input wire logic [PIX_W-1:0] out_data,
	output int n_pix,
	output int n_row,
	output int n_bad,
	output logic [PIX_W-1:0] first_px
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [PIX_W-1:0] last_px;

	// Source data is raster-coded, so each kept pixel after a frame's first must exceed the one before
	always @(posedge clock) begin
		if (out_valid && out_sof) begin
			n_pix <= 1;
			n_row <= int'(out_eol);
			n_bad <= 0;
			first_px <= out_data;
		end else if (out_valid) begin
			n_pix <= n_pix + 1;
			n_row <= n_row + int'(out_eol);
			if (out_data <= last_px)
				n_bad <= n_bad + 1;
		end
		if (out_valid)
			last_px <= out_data;
	end
endmodule : srmc_grabber

// [bench/tb_top.sv]
// Bench for the crop block: register tests and cropped frames.
// Assumes a 128 x 8 sensor so that a full frame stays short.
`include "srmc_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import srmc_pkg::*;
	localparam logic [15:0] SC = 16'h0080;
	localparam logic [15:0] SR = 16'h0008;
	logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic in_valid = 1'b0, in_sof = 1'b0, in_eol = 1'b0, pready, pslverr, rerr;
	logic out_valid, out_sof, out_eol;
	logic [11:0] paddr = 12'h000, in_data = 12'h000, out_data, first_px;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic [31:0] bad [4] = '{32'h0004_0048, 32'h0004_0030, 32'h0003_0040, 32'h0004_0090};
	int n_pix, n_row, n_bad, error_cnt = 0, n_compared = 0;

	srmc_top #(.SENSOR_COLS(SC), .SENSOR_ROWS(SR)) i_srmc_top (.clock, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_sof, .in_eol,
		.in_data, .out_valid, .out_sof, .out_eol, .out_data);
	srmc_grabber i_srmc_grabber (.clock, .out_valid, .out_sof, .out_eol, .out_data, .n_pix,
		.n_row, .n_bad, .first_px);

	always #25 clock = ~clock;

	// ----
	// Tasks
	// ----
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			t++;
		end while (pready !== 1'b1 && t < 16);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("FAIL %0t no pready", $time);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp, $sformatf("reg %h", a));
	endtask : rd

	task automatic region(input logic [31:0] s, e, r, o);
		wr(`SRMC_OFS_REG_SEL, s);
		wr(`SRMC_OFS_REG_EN, e);
		wr(`SRMC_OFS_REG_ROWS, r);
		wr(`SRMC_OFS_REG_START, o);
	endtask : region

	// Pixel value codes its own row and column, so order shows at the far side
	task automatic fchk(input int np, input int nr, input logic [11:0] fp);
		for (int r = 0; r < SR; r++)
			for (int c = 0; c < SC; c++) begin
				@(posedge clock);
				in_valid <= 1'b1;
				in_sof <= (r == 0 && c == 0);
				in_eol <= (c == SC - 1);
				in_data <= {r[4:0], c[6:0]};
			end
		@(posedge clock);
		in_valid <= 1'b0;
		repeat (3) @(posedge clock);
		chk(n_pix, np, "pixels");
		chk(n_row, nr, "rows");
		chk({20'h0, first_px}, {20'h0, fp}, "first pixel");
		chk(n_bad, 0, "order");
	endtask : fchk

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	// ----
	// Tests
	// ----
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(`SRMC_OFS_MAX, 32'h0008_0080);
		rd(`SRMC_OFS_WIN_SIZE, 32'h0008_0080);
		wr(`SRMC_OFS_SENSOR, 32'h0);
		rd(`SRMC_OFS_SENSOR, 32'h0008_0080);
		rd(`SRMC_OFS_STATUS, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped");
		fchk(1024, 8, 12'h000);
		$display("test reset done");
		foreach (bad[i]) begin
			wr(`SRMC_OFS_WIN_SIZE, bad[i]);
			rd(`SRMC_OFS_WIN_SIZE, 32'h0008_0080);
		end
		wr(`SRMC_OFS_WIN_SIZE, 32'h0004_0040);
		rd(`SRMC_OFS_WIN_SIZE, 32'h0004_0040);
		wr(`SRMC_OFS_WIN_START, 32'h0002_0010);
		fchk(256, 4, 12'h110);
		$display("test window done");
		wr(`SRMC_OFS_REG_COLS, 32'h18);
		rd(`SRMC_OFS_REG_COLS, 32'h0);
		wr(`SRMC_OFS_REG_COLS, 32'h20);
		region(32'h0, 32'h1, 32'h2, 32'h0004_0020);
		rd(`SRMC_OFS_STATUS, 32'h1);
		region(32'h1f, 32'h1, 32'h2, 32'h0);
		wr(`SRMC_OFS_REG_START, 32'h0000_0008);
		rd(`SRMC_OFS_REG_START, 32'h0);
		wr(`SRMC_OFS_CTRL, 32'h1);
		rd(`SRMC_OFS_STATUS, 32'h3);
		rd(`SRMC_OFS_OUT_SIZE, 32'h0004_0020);
		fchk(128, 4, 12'h000);
		wr(`SRMC_OFS_USERSET, 32'h1);
		wr(`SRMC_OFS_REG_EN, 32'h0);
		wr(`SRMC_OFS_REG_COLS, 32'h30);
		rd(`SRMC_OFS_OUT_SIZE, 32'h0002_0030);
		fchk(96, 2, 12'h220);
		wr(`SRMC_OFS_USERSET, 32'h2);
		rd(`SRMC_OFS_REG_COLS, 32'h20);
		rd(`SRMC_OFS_REG_EN, 32'h1);
		region(32'h0, 32'h1, 32'h2, 32'h0008_0020);
		rd(`SRMC_OFS_STATUS, 32'h0);
		fchk(256, 4, 12'h110);
		$display("test regions done");
		wrap_up();
	end

	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		$display("FAIL %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : tb_top
